// [logic/spen_notifier.sv]
// Top: per-port event notifier with interrupt and port-write request
`timescale 1ns/1ns
// Notes on behaviour
// - Max-retry event when port retry counter reaches configured threshold.
// - One retry counter per port counts retries of every packet.
// - Max-retry sets implementation error flag and max-retry flag.
// - Illegal transaction: bad maintenance type, no route entry, reserved type.
// - Illegal transaction sets implementation error flag; interrupt only.
// - Route table parity sets implementation and parity flags; both notices.
// - Reset-request event only after four consecutive reset symbols.
// - Reset-request sets port and global reset flags; interrupt only.
// - Fabric timeout sets port, global and fabric timeout flags.
// - Four link-requests answered with no outstanding ack give fatal error.
// - Four link-requests timing out give fatal error.
// - Fatal error sets port-error flag; both notices allowed.
// - Active-low interrupt asserts for any interrupt-enabled event.
// - Port-write sent only for capable events when enabled.
// - No priority between simultaneous events; each recorded independently.
module spen_notifier (
  // Clock and reset
  input  wire logic                                   i_clk,
  input  wire logic                                   i_rst_n,
  // Per-port raw events from the datapath
  input  wire logic [spen_pkg::NUM_PORTS-1:0]         i_retry,
  input  wire logic [spen_pkg::NUM_PORTS-1:0]         i_retry_clr,
  input  wire logic [spen_pkg::NUM_PORTS-1:0]         i_maint_bad_type,
  input  wire logic [spen_pkg::NUM_PORTS-1:0]         i_no_route,
  input  wire logic [spen_pkg::NUM_PORTS-1:0]         i_transport_type_rsvd,
  input  wire logic [spen_pkg::NUM_PORTS-1:0]         i_route_table_par_err,
  input  wire logic [spen_pkg::NUM_PORTS-1:0]         i_rst_sym,
  input  wire logic [spen_pkg::NUM_PORTS-1:0]         i_other_sym,
  input  wire logic [spen_pkg::NUM_PORTS-1:0]         i_fab_tmo,
  input  wire logic [spen_pkg::NUM_PORTS-1:0]         i_lreq_noack,
  input  wire logic [spen_pkg::NUM_PORTS-1:0]         i_lreq_tmo,
  input  wire logic [spen_pkg::NUM_PORTS-1:0]         i_lreq_ok,
  input  wire logic [spen_pkg::NUM_PORTS-1:0]         i_link_init,
  // Configuration
  input  wire logic [spen_pkg::RETRY_W-1:0]           i_retry_limit,
  input  wire logic [spen_pkg::NUM_F-1:0]             i_int_en,
  input  wire logic [spen_pkg::NUM_F-1:0]             i_pw_en,
  // Software clears, one vector per port, plus global clears
  input  wire logic [spen_pkg::NUM_PORTS*spen_pkg::NUM_F-1:0] i_clr,
  input  wire logic                                   i_glb_rsym_clr,
  input  wire logic                                   i_glb_tmo_clr,
  input  wire logic [spen_pkg::NUM_PORTS-1:0]         i_fab_clr,
  // Status
  output logic      [spen_pkg::NUM_PORTS*spen_pkg::NUM_F-1:0] o_port_flags,
  output logic                                        o_glb_rsym_flag,
  output logic                                        o_glb_tmo_flag,
  output logic      [spen_pkg::NUM_PORTS-1:0]         o_fab_tmo_flags,
  // Notification
  output logic                                        o_int_n,
  output logic                                        o_pw_req,
  output logic      [spen_pkg::NUM_PORTS-1:0]         o_pw_port
);
  // ==========================================================
  // Per-port logic
  logic [spen_pkg::NUM_PORTS*spen_pkg::NUM_F-1:0] evt;
  logic [spen_pkg::NUM_PORTS-1:0] pw_hit;
  logic [spen_pkg::NUM_PORTS-1:0] int_hit;
  logic [spen_pkg::NUM_PORTS-1:0] fab_reg, fab_next;
  logic glb_rsym_reg, glb_rsym_next;
  logic glb_tmo_reg, glb_tmo_next;
  logic int_reg, pw_reg;
  logic [spen_pkg::NUM_PORTS-1:0] pw_port_reg;
  wire  any_rsym;
  wire  any_tmo;

  for (genvar p = 0; p < spen_pkg::NUM_PORTS; p++) begin : g_port
    wire illegal;
    assign illegal = i_maint_bad_type[p] | i_no_route[p]
                     | i_transport_type_rsvd[p];
    spen_port u_port (
      .i_clk         (i_clk),
      .i_rst_n       (i_rst_n),
      .i_retry       (i_retry[p]),
      .i_retry_limit (i_retry_limit),
      .i_retry_clr   (i_retry_clr[p]),
      .i_illegal     (illegal),
      .i_par_err     (i_route_table_par_err[p]),
      .i_rst_sym     (i_rst_sym[p]),
      .i_other_sym   (i_other_sym[p]),
      .i_fab_tmo     (i_fab_tmo[p]),
      .i_lreq_noack  (i_lreq_noack[p]),
      .i_lreq_tmo    (i_lreq_tmo[p]),
      .i_lreq_ok     (i_lreq_ok[p]),
      .i_link_init   (i_link_init[p]),
      .i_clr         (i_clr[p*spen_pkg::NUM_F +: spen_pkg::NUM_F]),
      .o_flags       (o_port_flags[p*spen_pkg::NUM_F +: spen_pkg::NUM_F]),
      .o_evt         (evt[p*spen_pkg::NUM_F +: spen_pkg::NUM_F])
    );
    // Illegal transaction counts toward the implementation flag but
    // is kept out of the port-write path.
    wire [spen_pkg::NUM_F-1:0] e;
    wire                       impl_pw;
    assign e       = evt[p*spen_pkg::NUM_F +: spen_pkg::NUM_F];
    assign impl_pw = 1'b0;
    assign int_hit[p] = |(e & i_int_en);
    assign pw_hit[p]  = (|(e & spen_pkg::PW_CAPABLE & i_pw_en))
                        | (impl_pw & i_pw_en[spen_pkg::F_IMPL]);
  end

  // ==========================================================
  // Global and fabric timeout status
  assign any_rsym      = |(evt & {spen_pkg::NUM_PORTS{7'h08}});
  assign any_tmo       = |i_fab_tmo;
  assign glb_rsym_next = (glb_rsym_reg & ~i_glb_rsym_clr) | any_rsym;
  assign glb_tmo_next  = (glb_tmo_reg & ~i_glb_tmo_clr) | any_tmo;
  assign fab_next      = (fab_reg & ~i_fab_clr) | i_fab_tmo;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      glb_rsym_reg <= 1'b0;
      glb_tmo_reg  <= 1'b0;
      fab_reg      <= '0;
      int_reg      <= 1'b0;
      pw_reg       <= 1'b0;
      pw_port_reg  <= '0;
    end else begin
      glb_rsym_reg <= glb_rsym_next;
      glb_tmo_reg  <= glb_tmo_next;
      fab_reg      <= fab_next;
      int_reg      <= |int_hit;
      pw_reg       <= |pw_hit;
      pw_port_reg  <= pw_hit;
    end
  end

  assign o_glb_rsym_flag = glb_rsym_reg;
  assign o_glb_tmo_flag  = glb_tmo_reg;
  assign o_fab_tmo_flags = fab_reg;
  assign o_int_n         = ~int_reg;
  assign o_pw_req        = pw_reg;
  assign o_pw_port       = pw_port_reg;
endmodule // spen_notifier

// [logic/spen_pkg.sv]
// Package: constants for the switch port event notifier
package spen_pkg;
  // ==========================================================
  // Sizes
  localparam int NUM_PORTS     = 4;
  localparam int RETRY_W       = 8;
  localparam int REQ_CNT_W     = 3;
  // ==========================================================
  // Counts
  localparam logic [2:0] RST_REQ_RUN   = 3'h4;
  localparam logic [2:0] LINK_REQ_FAIL = 3'h4;
  // ==========================================================
  // Reset values
  localparam logic [RETRY_W-1:0]   RETRY_RST = 8'h00;
  localparam logic [REQ_CNT_W-1:0] CNT_RST   = 3'h0;
  // Per-port flag vector positions
  localparam int F_IMPL  = 0;
  localparam int F_RETRY = 1;
  localparam int F_PAR   = 2;
  localparam int F_RSYM  = 3;
  localparam int F_TMO   = 4;
  localparam int F_PERR  = 5;
  localparam int F_LINIT = 6;
  localparam int NUM_F   = 7;
  // Event kinds that may produce a port-write
  localparam logic [NUM_F-1:0] PW_CAPABLE = 7'h76;
  localparam logic [NUM_F-1:0] FLAGS_RST  = 7'h00;
endpackage

// [logic/spen_port.sv]
// One port's event detection, counters and sticky flags
`timescale 1ns/1ns
module spen_port (
  // Clock and reset
  input  wire logic                              i_clk,
  input  wire logic                              i_rst_n,
  // Events
  input  wire logic                              i_retry,
  input  wire logic [spen_pkg::RETRY_W-1:0]      i_retry_limit,
  input  wire logic                              i_retry_clr,
  input  wire logic                              i_illegal,
  input  wire logic                              i_par_err,
  input  wire logic                              i_rst_sym,
  input  wire logic                              i_other_sym,
  input  wire logic                              i_fab_tmo,
  input  wire logic                              i_lreq_noack,
  input  wire logic                              i_lreq_tmo,
  input  wire logic                              i_lreq_ok,
  input  wire logic                              i_link_init,
  // Software clears
  input  wire logic [spen_pkg::NUM_F-1:0]        i_clr,
  // Status
  output logic      [spen_pkg::NUM_F-1:0]        o_flags,
  output logic      [spen_pkg::NUM_F-1:0]        o_evt
);
  // ==========================================================
  // Counters
  logic [spen_pkg::RETRY_W-1:0]   retry_reg, retry_next;
  logic [spen_pkg::REQ_CNT_W-1:0] rsym_reg, rsym_next;
  logic [spen_pkg::REQ_CNT_W-1:0] noack_reg, noack_next;
  logic [spen_pkg::REQ_CNT_W-1:0] lto_reg, lto_next;
  logic [spen_pkg::NUM_F-1:0]     flags_reg, flags_next;
  wire retry_hit;
  wire rsym_hit;
  wire noack_hit;
  wire lto_hit;

  // One shared counter for all packets
  assign retry_hit  = i_retry &&
                      (retry_reg + 8'h01 >= i_retry_limit);
  assign retry_next = i_retry_clr ? spen_pkg::RETRY_RST :
                      retry_hit ? spen_pkg::RETRY_RST :
                      i_retry ? retry_reg + 8'h01 : retry_reg;
  // Any other symbol breaks the run
  assign rsym_hit   = i_rst_sym && (rsym_reg == spen_pkg::RST_REQ_RUN - 3'h1);
  assign rsym_next  = (i_other_sym || rsym_hit) ? spen_pkg::CNT_RST :
                      i_rst_sym ? rsym_reg + 3'h1 : rsym_reg;
  assign noack_hit  = i_lreq_noack &&
                      (noack_reg == spen_pkg::LINK_REQ_FAIL - 3'h1);
  assign noack_next = (i_lreq_ok || noack_hit) ? spen_pkg::CNT_RST :
                      i_lreq_noack ? noack_reg + 3'h1 : noack_reg;
  assign lto_hit    = i_lreq_tmo &&
                      (lto_reg == spen_pkg::LINK_REQ_FAIL - 3'h1);
  assign lto_next   = (i_lreq_ok || lto_hit) ? spen_pkg::CNT_RST :
                      i_lreq_tmo ? lto_reg + 3'h1 : lto_reg;

  // ==========================================================
  // Events, each independent of the others
  assign o_evt[spen_pkg::F_IMPL]  = retry_hit | i_illegal | i_par_err
                                    | i_fab_tmo;
  assign o_evt[spen_pkg::F_RETRY] = retry_hit;
  assign o_evt[spen_pkg::F_PAR]   = i_par_err;
  assign o_evt[spen_pkg::F_RSYM]  = rsym_hit;
  assign o_evt[spen_pkg::F_TMO]   = i_fab_tmo;
  assign o_evt[spen_pkg::F_PERR]  = noack_hit | lto_hit;
  assign o_evt[spen_pkg::F_LINIT] = i_link_init;

  // Set wins over clear so no event is lost
  assign flags_next = (flags_reg & ~i_clr) | o_evt;
  assign o_flags    = flags_reg;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      retry_reg <= spen_pkg::RETRY_RST;
      rsym_reg  <= spen_pkg::CNT_RST;
      noack_reg <= spen_pkg::CNT_RST;
      lto_reg   <= spen_pkg::CNT_RST;
      flags_reg <= spen_pkg::FLAGS_RST;
    end else begin
      retry_reg <= retry_next;
      rsym_reg  <= rsym_next;
      noack_reg <= noack_next;
      lto_reg   <= lto_next;
      flags_reg <= flags_next;
    end
  end
endmodule // spen_port

// [tb/spen_notifier_sva.sv]
// Checker: port-level assertions for the event notifier
`timescale 1ns/1ns
module spen_notifier_sva (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  // Watched inputs
  input wire logic [3:0]  i_fab_tmo,
  input wire logic [3:0]  i_maint_bad_type,
  input wire logic [3:0]  i_rst_sym,
  input wire logic [3:0]  i_link_init,
  input wire logic [6:0]  i_int_en,
  input wire logic [6:0]  i_pw_en,
  input wire logic [27:0] i_clr,
  input wire logic        i_glb_tmo_clr,
  // Watched outputs
  input wire logic [27:0] o_port_flags,
  input wire logic        o_glb_rsym_flag,
  input wire logic        o_glb_tmo_flag,
  input wire logic [3:0]  o_fab_tmo_flags,
  input wire logic        o_int_n,
  input wire logic        o_pw_req,
  input wire logic [3:0]  o_pw_port
);
  // ==========================================
  // Port 0 stands in for all ports
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_tmo_sets_flags: assert property (i_fab_tmo[0] |=> o_port_flags[4] &&
    o_port_flags[0] && o_glb_tmo_flag && o_fab_tmo_flags[0])
    else $error("timeout flags not set");
  a_tmo_int_pulse: assert property (i_fab_tmo[0] && i_int_en[4] |=> !o_int_n)
    else $error("no interrupt for timeout");
  a_tmo_port_write: assert property (i_fab_tmo[0] && i_pw_en[4] |=>
    o_pw_req && o_pw_port[0]) else $error("no port-write for timeout");
  a_pw_all_off: assert property (i_pw_en == 7'h00 |=> !o_pw_req)
    else $error("port-write while disabled");
  a_int_all_off: assert property (i_int_en == 7'h00 |=> o_int_n)
    else $error("interrupt while disabled");
  a_rsym_needs_sym: assert property ($rose(o_port_flags[3]) |->
    $past(i_rst_sym[0])) else $error("reset flag without symbol");
  a_rsym_global: assert property ($rose(o_port_flags[3]) |-> o_glb_rsym_flag)
    else $error("global reset flag missing");
  a_illegal_flag: assert property (i_maint_bad_type[0] |=> o_port_flags[0])
    else $error("illegal transaction not flagged");
  a_link_flag: assert property (i_link_init[0] |=> o_port_flags[6])
    else $error("link init not flagged");
  a_flag_sticky: assert property (o_port_flags[6] && !i_clr[6] |=>
    o_port_flags[6]) else $error("flag dropped without clear");
  a_glb_sticky: assert property (o_glb_tmo_flag && !i_glb_tmo_clr |=>
    o_glb_tmo_flag) else $error("global flag dropped");
  c_tmo: cover property (i_fab_tmo[0]);
  c_rsym: cover property ($rose(o_port_flags[3]));
  c_both: cover property (!o_int_n && o_pw_req);
endmodule // spen_notifier_sva
bind spen_notifier spen_notifier_sva u_sva (.*);

// [tb/spen_host_model.sv]
// Host model: tallies interrupt pulses and port-write requests
`timescale 1ns/1ns
module spen_host_model (
  // Clock
  input  wire logic       i_clk,
  // Notices from the switch
  input  wire logic       i_int_n,
  input  wire logic       i_pw_req,
  input  wire logic [3:0] i_pw_port,
  // Tallies
  output int              o_ints = 0,
  output int              o_pws = 0,
  output logic [3:0]      o_pw_last = 4'h0
);
  // ==========================================
  // Pulse notices: one count per low or high cycle
  always @(posedge i_clk) begin
    if (i_int_n === 1'b0) o_ints <= o_ints + 1;
    if (i_pw_req === 1'b1) begin
      o_pws <= o_pws + 1;
      o_pw_last <= i_pw_port;
    end
  end
endmodule // spen_host_model

// [tb/test_switch_port_event_notifier.sv]
// Testbench: event notifier scenarios against the host model
`timescale 1ns/1ns
module test_switch_port_event_notifier;
  // ==========================================
  // Stimulus, observation and tasks
  logic        i_clk = 1'b0, i_rst_n = 1'b0;
  logic [3:0]  i_retry = '0, i_retry_clr = '0, i_maint_bad_type = '0;
  logic [3:0]  i_no_route = '0, i_transport_type_rsvd = '0, i_rst_sym = '0;
  logic [3:0]  i_route_table_par_err = '0, i_other_sym = '0, i_fab_tmo = '0;
  logic [3:0]  i_lreq_noack = '0, i_lreq_tmo = '0, i_lreq_ok = '0;
  logic [3:0]  i_link_init = '0, i_fab_clr = '0;
  logic [7:0]  i_retry_limit = 8'h03;
  logic [6:0]  i_int_en = 7'h7f, i_pw_en = 7'h7f;
  logic [27:0] i_clr = '0;
  logic        i_glb_rsym_clr = 1'b0, i_glb_tmo_clr = 1'b0;
  wire  [27:0] o_port_flags;
  wire         o_glb_rsym_flag, o_glb_tmo_flag, o_int_n, o_pw_req;
  wire  [3:0]  o_fab_tmo_flags, o_pw_port, pw_last;
  int          ints, pws, i0, w0, fails = 0, total_checks = 0;
  always #20 i_clk = ~i_clk;
  spen_notifier DUT (.*);
  spen_host_model u_host (.i_clk(i_clk), .i_int_n(o_int_n),
    .i_pw_req(o_pw_req), .i_pw_port(o_pw_port), .o_ints(ints),
    .o_pws(pws), .o_pw_last(pw_last));
  function automatic logic [6:0] pf(input int p);
    return o_port_flags[p*7+:7];
  endfunction
  task automatic chk_v(input logic [6:0] g, input logic [6:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: flags %h not %h", $time, g, e);
    end
  endtask
  task automatic chk_n(input int g, input int e);
    total_checks++;
    if (g != e) begin
      fails++;
      $display("wrong value at %0t: notices %0d not %0d", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // Pulses one cause, then idles a cycle so the notice lands first
  task automatic fire(input int k, input logic [3:0] m);
    case (k)
      0: i_retry = m;
      1: i_maint_bad_type = m;
      2: i_no_route = m;
      3: i_transport_type_rsvd = m;
      4: i_route_table_par_err = m;
      5: i_rst_sym = m;
      6: i_other_sym = m;
      7: i_fab_tmo = m;
      8: i_lreq_noack = m;
      9: i_lreq_tmo = m;
      10: i_lreq_ok = m;
      default: i_retry_clr = m;
    endcase
    tick(1);
    {i_retry, i_maint_bad_type, i_no_route, i_transport_type_rsvd,
     i_route_table_par_err, i_rst_sym, i_other_sym, i_fab_tmo,
     i_lreq_noack, i_lreq_tmo, i_link_init, i_lreq_ok, i_retry_clr} = '0;
    tick(1);
  endtask
  task automatic clr();
    {i_clr, i_glb_rsym_clr, i_glb_tmo_clr, i_fab_clr} = '1;
    tick(1);
    {i_clr, i_glb_rsym_clr, i_glb_tmo_clr, i_fab_clr} = '0;
    tick(1);
    i0 = ints;
    w0 = pws;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    end_sim();
  end
  initial begin
    tick(16);
    i_rst_n = 1'b1;
    tick(1);
    clr();
    fire(7, 4'h1);
    chk_v(pf(0), 7'h11);
    chk_v({o_fab_tmo_flags, o_glb_tmo_flag, o_glb_rsym_flag}, 7'h06);
    chk_n(ints - i0, 1);
    chk_n(pws - w0, 1);
    tick(5);
    chk_v(pf(0), 7'h11);
    clr();
    chk_v(pf(0), 7'h00);
    $display("test timeout done");
    for (int k = 1; k < 4; k++) begin
      fire(k, 4'h2);
      chk_v(pf(1), 7'h01);
      chk_n(pws - w0, 0);
      chk_n(ints - i0, 1);
      clr();
    end
    $display("test illegal done");
    repeat (3) fire(5, 4'h1);
    fire(6, 4'h1);
    repeat (3) fire(5, 4'h1);
    chk_v(pf(0), 7'h00);
    fire(5, 4'h1);
    chk_v(pf(0), 7'h08);
    chk_v({6'h00, o_glb_rsym_flag}, 7'h01);
    chk_n(pws - w0, 0);
    clr();
    $display("test reset symbol done");
    // Retry clear must restart the shared count
    fire(0, 4'h4);
    fire(11, 4'h4);
    repeat (2) fire(0, 4'h4);
    chk_v(pf(2), 7'h00);
    fire(0, 4'h4);
    chk_v(pf(2), 7'h03);
    chk_n(pws - w0, 1);
    clr();
    $display("test retry done");
    repeat (4) fire(8, 4'h8);
    chk_v(pf(3), 7'h20);
    clr();
    // A good link-response breaks the run of failures
    repeat (3) fire(8, 4'h8);
    fire(10, 4'h8);
    fire(8, 4'h8);
    chk_v(pf(3), 7'h00);
    repeat (3) fire(9, 4'h8);
    chk_v(pf(3), 7'h00);
    fire(9, 4'h8);
    chk_v(pf(3), 7'h20);
    chk_n(pws - w0, 1);
    $display("test fatal done");
    // Disabled notices must still leave the flags behind
    {i_int_en, i_pw_en} = '0;
    clr();
    i_link_init = 4'h2;
    fire(4, 4'h1);
    chk_v(pf(0), 7'h05);
    chk_v(pf(1), 7'h40);
    chk_n(ints - i0, 0);
    chk_n(pws - w0, 0);
    {i_int_en, i_pw_en} = '1;
    clr();
    i_link_init = 4'h2;
    fire(4, 4'h1);
    chk_n(pws - w0, 1);
    chk_v({3'h0, pw_last}, 7'h03);
    $display("test simultaneous done");
    end_sim();
  end
endmodule // test_switch_port_event_notifier
